// ---- hdl/iab_pkg.sv ----
/*
  Register map, field positions, target codes, timing constants and carrier
  structs for the indirect access bridge control block.
  Assumes one 200 MHz clock domain; the register port comes from the serial
  control bus slave on the same clock.
*/
package iab_pkg;

  // ----------------------------------------------------------------
  // Register offsets on the serial control bus
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTL = 8'h48;
  localparam logic [7:0] OFS_ADDR_LO = 8'h49;
  localparam logic [7:0] OFS_ADDR_HI = 8'h4a;
  localparam logic [7:0] OFS_DATA0 = 8'h4b;
  localparam logic [7:0] OFS_DATA1 = 8'h4c;
  localparam logic [7:0] OFS_DATA2 = 8'h4d;
  localparam logic [7:0] OFS_DATA3 = 8'h4e;
  localparam logic [7:0] OFS_BRIDGE = 8'h4f;
  localparam logic [7:0] READ_ZERO = 8'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTL_SEL_LSB = 3;
  localparam int CTL_AUTO = 2;
  localparam int CTL_READ = 1;
  localparam int CTL_EN = 0;
  localparam int BR_SRC = 4;
  localparam int BR_CEC_EN = 3;
  localparam int BR_WIPE = 2;
  localparam int BR_RELOAD = 1;
  localparam int BR_BLOCK = 0;

  // ----------------------------------------------------------------
  // Targets, address steps and strap settling
  // ----------------------------------------------------------------
  localparam logic [1:0] TGT_RX = 2'h0;
  localparam logic [1:0] TGT_EDID = 2'h1;
  localparam logic [1:0] TGT_CFG = 2'h2;
  localparam logic [1:0] TGT_DIE = 2'h3;
  localparam logic [15:0] STEP_RX = 16'h0004;
  localparam logic [15:0] STEP_OTHER = 16'h0001;
  localparam logic [1:0] STRAP_SETTLE = 2'h2;
  localparam logic [1:0] STRAP_DONE = 2'h3;

  // ----------------------------------------------------------------
  // Timing: half periods of the CEC timebase, rounded down
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 200_000_000;
  localparam int OSC_HZ = 25_000_000;
  localparam int CEC_HZ = 32768;
  localparam int CNT_W = 13;
  localparam logic [CNT_W-1:0] HALF_INT = CNT_W'(CLK_HZ / (2 * CEC_HZ));
  localparam logic [CNT_W-1:0] HALF_OSC = CNT_W'(OSC_HZ / (2 * CEC_HZ));

  // ----------------------------------------------------------------
  // Carrier structs
  // ----------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } iab_reg_req_s;

  typedef struct packed {
    logic write;
    logic [1:0] target;
    logic [15:0] addr;
    logic [31:0] wdata;
  } iab_xfer_s;

  typedef struct packed {
    logic [3:0] psel;
    logic penable;
    logic pwrite;
    logic [15:0] paddr;
    logic [31:0] pwdata;
  } iab_apb_s;

endpackage

// ---- hdl/iab_apb_master.sv ----
/*
  Single-transfer APB master that runs one indirect read or write.
  Assumes targets on the same clock; one psel line per target.
*/
`timescale 1ns/1ps
`default_nettype none

module iab_apb_master (
  // Clock and reset.
  input wire logic clk,
  input wire logic resetn,
  // Request from the control registers.
  input wire logic start,
  input wire iab_pkg::iab_xfer_s xfer,
  output logic done,
  output logic [31:0] rdata,
  // Internal APB towards the four targets.
  output var iab_pkg::iab_apb_s apb,
  input wire logic [31:0] prdata,
  input wire logic pready
);

  typedef enum logic [1:0] {IAB_IDLE, IAB_SETUP, IAB_ACCESS} iab_phase_e;
  typedef struct packed {
    iab_phase_e phase;
    iab_pkg::iab_xfer_s x;
    logic [31:0] rdata;
    logic done;
  } iab_master_s;

  iab_master_s st;
  iab_master_s next_st;

  // Setup then access phase; a start while busy is not expected.
  always_comb begin
    next_st = st;
    next_st.done = 1'b0;
    unique case (st.phase)
      IAB_IDLE: begin
        if (start) begin
          next_st.x = xfer;
          next_st.phase = IAB_SETUP;
        end
      end
      IAB_SETUP: begin
        next_st.phase = IAB_ACCESS;
      end
      IAB_ACCESS: begin
        if (pready) begin
          if (!st.x.write) begin
            next_st.rdata = prdata;
          end
          next_st.done = 1'b1;
          next_st.phase = IAB_IDLE;
        end
      end
      default: begin
        next_st.phase = IAB_IDLE;
      end
    endcase
  end

  // State register.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Bus outputs follow the latched request.
  assign apb.psel = (st.phase == IAB_IDLE) ? 4'h0 : (4'h1 << st.x.target);
  assign apb.penable = (st.phase == IAB_ACCESS);
  assign apb.pwrite = st.x.write;
  assign apb.paddr = st.x.addr;
  assign apb.pwdata = st.x.wdata;
  assign done = st.done;
  assign rdata = st.rdata;

endmodule

`default_nettype wire

// ---- hdl/iab_cec_timebase.sv ----
/*
  CEC timebase: a 32.768 kHz square wave and a tick on its rising edge,
  from the system clock or from the 25 MHz oscillator pin.
  Assumes the oscillator pin is asynchronous and far below clk / 2.
*/
`timescale 1ns/1ps
`default_nettype none

module iab_cec_timebase (
  // Clock and reset.
  input wire logic clk,
  input wire logic resetn,
  // Control.
  input wire logic enable,
  input wire logic source,
  // Oscillator pin.
  input wire logic osc_pin,
  // Timebase outputs.
  output logic cec_clk,
  output logic cec_tick
);

  typedef struct packed {
    logic [1:0] osc_sync;
    logic osc_prev;
    logic [iab_pkg::CNT_W-1:0] cnt;
    logic lvl;
    logic tick;
  } iab_cec_s;

  iab_cec_s st;
  iab_cec_s next_st;
  logic step;
  logic [iab_pkg::CNT_W-1:0] half;

  // Count half periods; the oscillator path counts its rising edges only.
  // A source switch can leave the count past the new end, so >= ends that
  // half at once instead of running the counter all the way round.
  always_comb begin
    next_st = st;
    next_st.osc_sync = {st.osc_sync[0], osc_pin};
    next_st.osc_prev = st.osc_sync[1];
    next_st.tick = 1'b0;
    step = source ? (st.osc_sync[1] & ~st.osc_prev) : 1'b1;
    half = source ? iab_pkg::HALF_OSC : iab_pkg::HALF_INT;
    if (!enable) begin
      next_st.cnt = '0; // R10
      next_st.lvl = 1'b0;
    end else if (step) begin
      if (st.cnt >= half - 1'b1) begin
        next_st.cnt = '0; // R9
        next_st.lvl = ~st.lvl;
        next_st.tick = ~st.lvl;
      end else begin
        next_st.cnt = st.cnt + 1'b1;
      end
    end
  end

  // State register.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign cec_clk = st.lvl;
  assign cec_tick = st.tick;

  // A disabled timebase goes quiet on the next edge.
  cec_off_a: assert property (@(posedge clk) disable iff (!resetn) // R10
    !enable |=> !cec_tick && !cec_clk)
    else $error("CEC timebase active while disabled");

endmodule

`default_nettype wire

// ---- hdl/iab_bridge_control.sv ----
/*
  Control registers of the indirect access bridge: address and data windows,
  target selection, CEC timebase control, display ID memory reload/wipe and
  the strapped DDC block bit.
  Assumes a byte register port from the serial control bus slave on clk,
  an EEPROM loader that answers reload requests, and targets on clk.
*/
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// R1 - Two-bit target field picks receive regs, ID memory, config or die id.
// R2 - Auto-increment adds four for receive target, one otherwise, per transfer.
// R3 - Writing one to read-start reads the target into the data window.
// R4 - Host loads both address bytes before setting read-start.
// R5 - Device clears read-start when the read is done; host may poll.
// R6 - Indirect access runs only while enabled; target field selects target.
// R7 - Sixteen-bit address in two byte registers, low first, reset zero.
// R8 - Thirty-two-bit data in four byte registers, least significant first.
// R9 - Source bit picks internal clock or 25 MHz oscillator for CEC.
// R10 - Enable bit turns the 32.768 kHz CEC timebase on or off.
// R11 - Host enables the CEC timebase before enabling CEC itself.
// R12 - Memory wipe happens only with wipe and reload written together.
// R13 - Reload refills memory from EEPROM; device clears both bits after.
// R14 - Read-only DDC block bit captures the strap pin after reset.
// R15 - Writes aimed at config data or die id are dropped.
module iab_bridge_control (
  // Clock and reset.
  input wire logic clk,
  input wire logic resetn,
  // Register port from the serial control bus slave.
  input wire iab_pkg::iab_reg_req_s reg_req,
  output logic [7:0] reg_rdata,
  // Indirect access bus.
  output var iab_pkg::iab_apb_s apb,
  input wire logic [31:0] apb_prdata,
  input wire logic apb_pready,
  // Display ID memory loader.
  output logic edid_reload_req,
  output logic edid_wipe_req,
  input wire logic edid_reload_done,
  output logic display_id_ddc_block,
  // Pins.
  input wire logic mode_strap_pin_zero,
  input wire logic osc_pin,
  // CEC timebase.
  output logic cec_clk,
  output logic cec_tick
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------

  // Address step after one transfer to the given target.
  function automatic logic [15:0] addr_step(input logic [1:0] tgt);
    return (tgt == iab_pkg::TGT_RX) ? iab_pkg::STEP_RX : iab_pkg::STEP_OTHER;
  endfunction

  // Only the receive registers and the ID memory accept writes.
  function automatic logic is_writable(input logic [1:0] tgt);
    return (tgt == iab_pkg::TGT_RX) || (tgt == iab_pkg::TGT_EDID);
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------

  typedef struct packed {
    logic [1:0] sel;
    logic auto_inc;
    logic rd_req;
    logic en;
    logic [15:0] addr;
    logic [31:0] data;
    logic cec_src;
    logic cec_en;
    logic wipe;
    logic reload;
    logic block;
    logic [1:0] strap_sync;
    logic [1:0] strap_cnt;
    logic wr_pend;
    logic busy;
    logic busy_wr;
    logic [1:0] busy_tgt;
    logic [7:0] rdata;
  } iab_ctl_s;

  iab_ctl_s st;
  iab_ctl_s next_st;

  logic wr_ctl;
  logic wr_addr_lo;
  logic wr_addr_hi;
  logic wr_data0;
  logic wr_data3;
  logic wr_data_any;
  logic wr_bridge;
  logic start;
  iab_pkg::iab_xfer_s xfer;
  logic apb_done;
  logic [31:0] apb_rdata;
  logic [7:0] d;

  // ----------------------------------------------------------------
  // Register write decode
  // ----------------------------------------------------------------

  // Write strobes per register; the data window has one for any byte plus data0 and data3.
  assign d = reg_req.wdata;
  assign wr_ctl = reg_req.wr && (reg_req.addr == iab_pkg::OFS_CTL);
  assign wr_addr_lo = reg_req.wr && (reg_req.addr == iab_pkg::OFS_ADDR_LO);
  assign wr_addr_hi = reg_req.wr && (reg_req.addr == iab_pkg::OFS_ADDR_HI);
  assign wr_data0 = reg_req.wr && (reg_req.addr == iab_pkg::OFS_DATA0);
  assign wr_data3 = reg_req.wr && (reg_req.addr == iab_pkg::OFS_DATA3);
  assign wr_data_any = reg_req.wr && (reg_req.addr >= iab_pkg::OFS_DATA0)
                       && (reg_req.addr <= iab_pkg::OFS_DATA3);
  assign wr_bridge = reg_req.wr && (reg_req.addr == iab_pkg::OFS_BRIDGE);

  // ----------------------------------------------------------------
  // Transfer launch
  // ----------------------------------------------------------------

  // A pending read goes first, so a poll never waits behind a pending write.
  assign start = !st.busy && st.en && (st.rd_req || st.wr_pend); // R6
  assign xfer.write = !st.rd_req;
  assign xfer.target = st.sel; // R1
  assign xfer.addr = st.addr;
  assign xfer.wdata = st.data;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------

  // Hardware updates come first; host writes then override data and
  // address, while hardware-cleared flags let a host set win.
  always_comb begin
    next_st = st;

    // Strap capture: wait for the synchroniser to fill, then sample once.
    next_st.strap_sync = {st.strap_sync[0], mode_strap_pin_zero};
    if (st.strap_cnt != iab_pkg::STRAP_DONE) begin
      next_st.strap_cnt = st.strap_cnt + 2'h1;
    end
    if (st.strap_cnt == iab_pkg::STRAP_SETTLE) begin
      next_st.block = st.strap_sync[1]; // R14
    end

    // Launch bookkeeping.
    if (start) begin
      next_st.busy = 1'b1;
      next_st.busy_wr = xfer.write;
      next_st.busy_tgt = st.sel;
      if (xfer.write) begin
        next_st.wr_pend = 1'b0;
      end
    end

    // Completion: capture read data, drop read-start, step the address.
    if (apb_done) begin
      next_st.busy = 1'b0;
      if (!st.busy_wr) begin
        next_st.data = apb_rdata; // R3
        next_st.rd_req = 1'b0; // R5
      end
      if (st.auto_inc) begin
        next_st.addr = st.addr + addr_step(st.busy_tgt); // R2
      end
    end

    // Loader finished: both memory bits drop together.
    if (edid_reload_done) begin
      next_st.reload = 1'b0; // R13
      next_st.wipe = 1'b0;
    end

    // Host writes to the access control register.
    if (wr_ctl) begin
      next_st.sel = d[iab_pkg::CTL_SEL_LSB +: 2]; // R1
      next_st.auto_inc = d[iab_pkg::CTL_AUTO];
      next_st.en = d[iab_pkg::CTL_EN]; // R6
      if (d[iab_pkg::CTL_READ]) begin
        next_st.rd_req = 1'b1; // R3
      end
      // A write still waiting must not follow the select to a read-only target.
      if (!is_writable(d[iab_pkg::CTL_SEL_LSB +: 2])) begin
        next_st.wr_pend = 1'b0; // R15
      end
    end

    // Address window, low byte first.
    if (wr_addr_lo) begin
      next_st.addr[7:0] = d; // R7
    end
    if (wr_addr_hi) begin
      next_st.addr[15:8] = d; // R7
    end

    // Data window, least significant byte at the lowest offset.
    if (wr_data_any) begin
      next_st.data[8 * (reg_req.addr - iab_pkg::OFS_DATA0) +: 8] = d; // R8
    end

    // The top byte commits an indirect write to a writable target.
    if (wr_data3 && st.en && is_writable(st.sel)) begin
      next_st.wr_pend = 1'b1; // R15
    end

    // Bridge control; the wipe bit only takes with a reload in the same write.
    if (wr_bridge) begin
      next_st.cec_src = d[iab_pkg::BR_SRC]; // R9
      next_st.cec_en = d[iab_pkg::BR_CEC_EN]; // R10
      if (d[iab_pkg::BR_RELOAD]) begin
        next_st.reload = 1'b1; // R13
        next_st.wipe = d[iab_pkg::BR_WIPE]; // R12
      end
    end

    // Read data is registered, so it appears one cycle after the strobe.
    if (reg_req.rd) begin
      unique case (reg_req.addr)
        iab_pkg::OFS_CTL: begin
          next_st.rdata = {3'h0, st.sel, st.auto_inc, st.rd_req, st.en};
        end
        iab_pkg::OFS_ADDR_LO: begin
          next_st.rdata = st.addr[7:0];
        end
        iab_pkg::OFS_ADDR_HI: begin
          next_st.rdata = st.addr[15:8];
        end
        iab_pkg::OFS_DATA0: begin
          next_st.rdata = st.data[7:0];
        end
        iab_pkg::OFS_DATA1: begin
          next_st.rdata = st.data[15:8];
        end
        iab_pkg::OFS_DATA2: begin
          next_st.rdata = st.data[23:16];
        end
        iab_pkg::OFS_DATA3: begin
          next_st.rdata = st.data[31:24];
        end
        iab_pkg::OFS_BRIDGE: begin
          next_st.rdata = {3'h0, st.cec_src, st.cec_en, st.wipe, st.reload,
                           st.block};
        end
        default: begin
          next_st.rdata = iab_pkg::READ_ZERO;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------

  // Every field resets to zero, the documented reset of each register.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Submodules
  // ----------------------------------------------------------------

  // Indirect bus master.
  iab_apb_master u_master (
    .clk(clk),
    .resetn(resetn),
    .start(start),
    .xfer(xfer),
    .done(apb_done),
    .rdata(apb_rdata),
    .apb(apb),
    .prdata(apb_prdata),
    .pready(apb_pready)
  );

  // CEC timebase generator.
  iab_cec_timebase u_cec (
    .clk(clk),
    .resetn(resetn),
    .enable(st.cec_en),
    .source(st.cec_src),
    .osc_pin(osc_pin),
    .cec_clk(cec_clk),
    .cec_tick(cec_tick)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------

  assign reg_rdata = st.rdata;
  assign edid_reload_req = st.reload;
  assign edid_wipe_req = st.wipe & st.reload; // R12
  assign display_id_ddc_block = st.block; // R14

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  tgt_select_a: assert property (start |=> apb.psel == (4'h1 << $past(st.sel))) // R1
    else $error("Wrong target selected");

  addr_step_a: assert property ( // R2
    apb_done && st.auto_inc && !wr_addr_lo && !wr_addr_hi
    |=> st.addr == $past(st.addr) + addr_step($past(st.busy_tgt)))
    else $error("Address step wrong");

  rd_launch_a: assert property ( // R3
    st.en && st.rd_req && !st.busy |-> start && !xfer.write ##2 apb.penable)
    else $error("Read not launched");

  rd_data_a: assert property ( // R3
    apb_done && !st.busy_wr && !wr_data_any |=> st.data == $past(apb_rdata))
    else $error("Read data not captured");

  rd_clear_a: assert property ( // R5
    apb_done && !st.busy_wr && !(wr_ctl && d[iab_pkg::CTL_READ]) |=> !st.rd_req)
    else $error("Read-start not cleared");

  en_gate_a: assert property (!st.en |-> !start) // R6
    else $error("Access while disabled");

  addr_byte_a: assert property (wr_addr_hi |=> st.addr[15:8] == $past(d)) // R7
    else $error("Address high byte not stored");

  data_byte_a: assert property (wr_data0 |=> st.data[7:0] == $past(d)) // R8
    else $error("Data byte zero not stored");

  wipe_pair_a: assert property ( // R12
    wr_bridge && !d[iab_pkg::BR_RELOAD] && !st.wipe |=> !edid_wipe_req)
    else $error("Wipe without reload");

  reload_clr_a: assert property ( // R13
    edid_reload_done && !wr_bridge |=> !edid_reload_req && !edid_wipe_req)
    else $error("Reload bits not cleared");

  strap_hold_a: assert property ( // R14
    st.strap_cnt == iab_pkg::STRAP_DONE |=> $stable(display_id_ddc_block))
    else $error("Strap bit changed after capture");

  ro_target_a: assert property (start && xfer.write |-> is_writable(st.sel)) // R15
    else $error("Write to read-only target");

  rd_done_c: cover property (apb_done && !st.busy_wr);
  wr_done_c: cover property (apb_done && st.busy_wr && st.auto_inc);
  reload_c: cover property (edid_wipe_req ##1 edid_reload_done);

endmodule

`default_nettype wire

// ---- verification/iab_far_side_model.sv ----
/*
  Far side of the indirect bus: four targets that answer after a chosen stall
  and record each accepted write, plus the display ID memory loader.
  Assumes the block drives the bus and the reload request on clk.
*/
`timescale 1ns/1ps
`default_nettype none

module iab_far_side_model (
  // Clock.
  input wire logic clk,
  // Indirect bus from the block.
  input wire iab_pkg::iab_apb_s apb,
  input wire logic [1:0] wait_cycles,
  output logic [31:0] prdata,
  output logic pready,
  // Last accepted write.
  output logic [3:0] wr_sel,
  output logic [15:0] wr_addr,
  output logic [31:0] wr_data,
  // Display ID memory loader.
  input wire logic reload_req,
  output logic reload_done
);
  logic [1:0] stall;
  logic [2:0] busy;
  logic tog;

  // Known start so that a dropped write is seen as no change.
  initial begin
    stall = 2'h0;
    busy = 3'h0;
    tog = 1'b0;
    wr_sel = 4'h0;
    wr_addr = 16'h0000;
    wr_data = 32'h0000_0000;
  end

  // Ready after the stall; read word names the target and the address.
  assign pready = apb.penable && (stall == wait_cycles);
  // Outside an accepted cycle the data flips each clock, so a stale capture shows.
  assign prdata = pready ? {apb.psel, 12'h000, apb.paddr} : {32{tog}};
  // The loader takes six cycles per request.
  assign reload_done = reload_req && (busy == 3'h5);

  // Stall and loader counters, write record.
  always @(posedge clk) begin
    tog <= ~tog;
    stall <= (apb.penable && !pready) ? stall + 2'h1 : 2'h0;
    busy <= (reload_req && !reload_done) ? busy + 3'h1 : 3'h0;
    if (pready && apb.pwrite) begin
      wr_sel <= apb.psel;
      wr_addr <= apb.paddr;
      wr_data <= apb.pwdata;
    end
  end
endmodule

`default_nettype wire

// ---- verification/indirect_apb_access_bridge_control_bench.sv ----
/*
  Self-checking bench for the indirect access bridge control block.
  Assumes the far side model beside it and a 25 MHz oscillator pin.
*/
`timescale 1ns/1ps
`default_nettype none

module indirect_apb_access_bridge_control_bench;
  logic clk, resetn, strap, osc, pready, rl_req, wp_req, rl_done, ddc_blk, cec_clk, cec_tick;
  iab_pkg::iab_reg_req_s reg_req;
  iab_pkg::iab_apb_s apb;
  logic [7:0] rdata;
  logic [31:0] prdata, wr_data;
  logic [1:0] waits;
  logic [3:0] wr_sel;
  logic [15:0] wr_addr, lfsr;
  int miscompares, n_tests;

  iab_bridge_control dut_u (.clk(clk), .resetn(resetn), .reg_req(reg_req), .reg_rdata(rdata),
    .apb(apb), .apb_prdata(prdata), .apb_pready(pready), .edid_reload_req(rl_req),
    .edid_wipe_req(wp_req), .edid_reload_done(rl_done), .display_id_ddc_block(ddc_blk),
    .mode_strap_pin_zero(strap), .osc_pin(osc), .cec_clk(cec_clk), .cec_tick(cec_tick));
  iab_far_side_model far_u (.clk(clk), .apb(apb), .wait_cycles(waits), .prdata(prdata),
    .pready(pready), .wr_sel(wr_sel), .wr_addr(wr_addr), .wr_data(wr_data),
    .reload_req(rl_req), .reload_done(rl_done));

  // ----------------------------------------------------------------
  // Clocks, watchdog and helpers
  // ----------------------------------------------------------------
  // System clock at 200 MHz and oscillator pin at 25 MHz.
  initial begin
    clk = 1'b0;
    osc = 1'b0;
    fork
      forever #2.5 clk = ~clk;
      forever #20 osc = ~osc;
    join
  end

  // The run needs about 45000 cycles; a hang is cut well past that.
  initial begin
    repeat (90000) @(posedge clk);
    miscompares++;
    summarize();
  end

  function automatic logic [15:0] nxt(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  function automatic logic [15:0] step(input logic [1:0] s);
    return (s == iab_pkg::TGT_RX) ? iab_pkg::STEP_RX : iab_pkg::STEP_OTHER;
  endfunction

  task automatic summarize;
    $display("Checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One register write; the strobe drops one edge later.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    reg_req.wr <= 1'b0;
  endtask

  // Reads n bytes from consecutive offsets, least significant first.
  task automatic rdn(input logic [7:0] base, input int n, output logic [31:0] v);
    v = 32'h0;
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      reg_req <= '{wr: 1'b0, rd: 1'b1, addr: base + 8'(i), wdata: 8'h00};
      @(posedge clk);
      reg_req.rd <= 1'b0;
      #1 v[8*i +: 8] = rdata;
    end
  endtask

  task automatic ind_read(input logic [1:0] sel, input logic [15:0] a);
    logic [31:0] v;
    v = 32'h2;
    wr(8'h49, a[7:0]);
    wr(8'h4a, a[15:8]);
    wr(8'h48, {3'h0, sel, 3'b111});
    for (int i = 0; i < 40 && v[1]; i++) rdn(8'h48, 1, v);
    check("read busy", {31'h0, v[1]}, 32'h0);
    rdn(8'h4b, 4, v);
    check("read window", v, {4'h1 << sel, 12'h000, a});
    rdn(8'h49, 2, v);
    check("read next addr", v, {16'h0, a + step(sel)});
  endtask

  task automatic ind_write(input logic [1:0] sel, input logic [15:0] a, input logic [31:0] d);
    logic [3:0] ps;
    logic [31:0] v;
    logic ok;
    ps = wr_sel;
    ok = (sel == iab_pkg::TGT_RX) || (sel == iab_pkg::TGT_EDID);
    wr(8'h49, a[7:0]);
    wr(8'h4a, a[15:8]);
    wr(8'h48, {3'h0, sel, 3'b101});
    for (int i = 0; i < 4; i++) wr(8'h4b + 8'(i), d[8*i +: 8]);
    repeat (12) @(posedge clk);
    check("write target", {28'h0, wr_sel}, {28'h0, ok ? 4'h1 << sel : ps});
    if (ok) check("write word", wr_data, d);
    if (ok) check("write addr", {16'h0, wr_addr}, {16'h0, a});
    rdn(8'h49, 2, v);
    check("write next addr", v, {16'h0, ok ? a + step(sel) : a});
  endtask

  // Cycles between two timebase ticks, bounded.
  task automatic tick_gap(output int n);
    n = 0;
    for (int k = 0; k < 8000 && !cec_tick; k++) begin
      @(posedge clk);
      #1;
    end
    do begin
      @(posedge clk);
      #1 n++;
    end while (!cec_tick && n < 8000);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] v;
    int n;
    reg_req = '0;
    resetn = 1'b0;
    strap = 1'b1;
    waits = 2'h0;
    lfsr = 16'h0011;
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    repeat (5) @(posedge clk);
    #1 check("ddc block", {31'h0, ddc_blk}, 32'h1);
    for (int a = 8'h47; a <= 8'h50; a++) begin
      rdn(8'(a), 1, v);
      check("reset value", v, (a == 8'h4f) ? 32'h1 : 32'h0);
    end
    // Data window keeps what the host writes, byte by byte.
    lfsr = nxt(lfsr);
    v = {lfsr, nxt(lfsr)};
    for (int i = 0; i < 4; i++) wr(8'h4b + 8'(i), v[8*i +: 8]);
    rdn(8'h4b, 4, v);
    check("data window", v, {lfsr, nxt(lfsr)});
    // A read asked for while disabled waits for the enable.
    wr(8'h49, 8'h34);
    wr(8'h4a, 8'h12);
    wr(8'h48, 8'h02);
    repeat (10) @(posedge clk);
    #1 check("idle select", {28'h0, apb.psel}, 32'h0);
    wr(8'h48, 8'h03);
    repeat (12) @(posedge clk);
    rdn(8'h48, 4, v);
    check("pending read", v, 32'h34123401);
    ind_read(iab_pkg::TGT_RX, 16'hfffc);
    ind_read(iab_pkg::TGT_DIE, 16'hffff);
    for (int s = 0; s < 8; s++) begin
      lfsr = nxt(lfsr);
      waits <= lfsr[3:2];
      ind_read(2'(s), lfsr);
      ind_write(2'(s), ~lfsr, {lfsr, nxt(lfsr)});
    end
    // Wipe alone is dropped; wipe with reload runs and both clear.
    wr(8'h4f, 8'h04);
    #1 check("wipe alone", {31'h0, wp_req}, 32'h0);
    for (int m = 0; m < 2; m++) begin
      wr(8'h4f, m ? 8'h06 : 8'h02);
      #1 check("reload req", {30'h0, wp_req, rl_req}, {30'h0, 1'(m), 1'b1});
      for (int i = 0; i < 20 && rl_req; i++) @(negedge clk);
      rdn(8'h4f, 1, v);
      check("reload cleared", v, 32'h1);
    end
    // Timebase enabled before any CEC use, first from clk, then from the pin.
    wr(8'h4f, 8'h08);
    tick_gap(n);
    check("internal period", n, 2 * int'(iab_pkg::HALF_INT));
    wr(8'h4f, 8'h18);
    tick_gap(n);
    tick_gap(n);
    check("osc period", {31'h0, n > 6080 && n < 6112}, 32'h1);
    wr(8'h4f, 8'h00);
    tick_gap(n);
    check("timebase off", {30'h0, cec_clk, n == 8000}, 32'h1);
    // A second reset recaptures the strap, now low.
    @(posedge clk);
    strap <= 1'b0;
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    repeat (5) @(posedge clk);
    #1 check("strap low", {31'h0, ddc_blk}, 32'h0);
    summarize();
  end
endmodule

`default_nettype wire
